// File: common/jsug_defs.svh
`ifndef JSUG_DEFS_SVH
`define JSUG_DEFS_SVH

`define JSUG_KEY_W        128
`define JSUG_OTP_ADDR     32'hf0000000
`define JSUG_FACTORY_CODE 128'h0123456789abcdef_fedcba9876543210
`define JSUG_TIEOFF       128'hffffffffffffffff_0000000000000000
`define JSUG_REFERENCE    128'h0123456789abcdef_0123456789abcdef
`define JSUG_SEC_PORT     2
`define JSUG_NUM_SEC      4
`define JSUG_BSR_LEN      8
`define JSUG_IR_W         4
`define JSUG_IR_RESET     4'h1
`define JSUG_IR_EXTEST    4'h0
`define JSUG_IR_SAMPLE    4'h2
`define JSUG_IR_ROUTE     4'h7
`define JSUG_IR_SECDR     4'h8
`define JSUG_IR_TESTTAP   4'h9
`define JSUG_IR_BYPASS    4'hf
`define JSUG_TLR_TMS_CNT  3'h5

`endif

// File: common/jsug_pkg.sv
package jsug_pkg;

    typedef enum logic [3:0] {
        TAP_RESET    = 4'h0,
        TAP_IDLE     = 4'h1,
        TAP_SEL_DR   = 4'h2,
        TAP_CAP_DR   = 4'h3,
        TAP_SHIFT_DR = 4'h4,
        TAP_EXIT1_DR = 4'h5,
        TAP_PAUSE_DR = 4'h6,
        TAP_EXIT2_DR = 4'h7,
        TAP_UPD_DR   = 4'h8,
        TAP_SEL_IR   = 4'h9,
        TAP_CAP_IR   = 4'ha,
        TAP_SHIFT_IR = 4'hb,
        TAP_EXIT1_IR = 4'hc,
        TAP_PAUSE_IR = 4'hd,
        TAP_EXIT2_IR = 4'he,
        TAP_UPD_IR   = 4'hf
    } jsug_tap_t;

    typedef enum logic [2:0] {
        TGT_BYPASS = 3'h0,
        TGT_ROUTE  = 3'h1,
        TGT_KEY    = 3'h2,
        TGT_SEC    = 3'h3,
        TGT_TEST   = 3'h4,
        TGT_BSR    = 3'h5
    } jsug_tgt_t;

endpackage : jsug_pkg

// File: verilog/jsug_tap_fsm.sv
`timescale 1ns/100ps
`include "jsug_defs.svh"
module jsug_tap_fsm (
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                tck_rise_in,
    input  wire logic                tms_in,
    output jsug_pkg::jsug_tap_t      state_out
);
    import jsug_pkg::*;

    jsug_tap_t state_q;
    jsug_tap_t state_d;

    always_comb begin
        state_d = state_q;
        if (tck_rise_in) begin
            case (state_q)
                TAP_RESET:    state_d = tms_in ? TAP_RESET    : TAP_IDLE;
                TAP_IDLE:     state_d = tms_in ? TAP_SEL_DR   : TAP_IDLE;
                TAP_SEL_DR:   state_d = tms_in ? TAP_SEL_IR   : TAP_CAP_DR;
                TAP_CAP_DR:   state_d = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_SHIFT_DR: state_d = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_EXIT1_DR: state_d = tms_in ? TAP_UPD_DR   : TAP_PAUSE_DR;
                TAP_PAUSE_DR: state_d = tms_in ? TAP_EXIT2_DR : TAP_PAUSE_DR;
                TAP_EXIT2_DR: state_d = tms_in ? TAP_UPD_DR   : TAP_SHIFT_DR;
                TAP_UPD_DR:   state_d = tms_in ? TAP_SEL_DR   : TAP_IDLE;
                TAP_SEL_IR:   state_d = tms_in ? TAP_RESET    : TAP_CAP_IR;
                TAP_CAP_IR:   state_d = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_SHIFT_IR: state_d = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_EXIT1_IR: state_d = tms_in ? TAP_UPD_IR   : TAP_PAUSE_IR;
                TAP_PAUSE_IR: state_d = tms_in ? TAP_EXIT2_IR : TAP_PAUSE_IR;
                TAP_EXIT2_IR: state_d = tms_in ? TAP_UPD_IR   : TAP_SHIFT_IR;
                TAP_UPD_IR:   state_d = tms_in ? TAP_SEL_DR   : TAP_IDLE;
                default:      state_d = TAP_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= TAP_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign state_out = state_q;

    // Five rising edges with TMS high always end in test-logic reset
    logic [2:0] tms_run_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tms_run_q <= 3'h0;
        end else if (tck_rise_in) begin
            if (!tms_in) begin
                tms_run_q <= 3'h0;
            end else if (tms_run_q != `JSUG_TLR_TMS_CNT) begin
                tms_run_q <= tms_run_q + 3'h1;
            end
        end
    end

    a_tms_reset: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        tms_run_q == `JSUG_TLR_TMS_CNT |-> state_q == TAP_RESET)
        else $error("TAP not in reset after five TMS-high edges");

endmodule : jsug_tap_fsm

// File: verilog/jsug_key_eval.sv
`timescale 1ns/100ps
`include "jsug_defs.svh"
module jsug_key_eval (
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    input  wire logic                    por_n_in,
    input  wire logic                    otp_prog_in,
    input  wire logic [31:0]             otp_addr_in,
    input  wire logic [`JSUG_KEY_W-1:0]  otp_data_in,
    input  wire logic                    key_load_in,
    input  wire logic [`JSUG_KEY_W-1:0]  key_data_in,
    output logic                         unlock_out
);
    import jsug_pkg::*;

    logic [`JSUG_KEY_W-1:0] otp_q;
    logic [`JSUG_KEY_W-1:0] otp_d;
    logic [`JSUG_KEY_W-1:0] key_q;
    logic [`JSUG_KEY_W-1:0] key_d;
    logic                   unlock_q;
    logic                   unlock_d;

    // Secret mixing with hidden tie-offs
    function automatic logic [`JSUG_KEY_W-1:0] scramble(
        input logic [`JSUG_KEY_W-1:0] x);
        scramble = {x[63:0], x[127:64]} ^ `JSUG_TIEOFF;
    endfunction : scramble

    function automatic logic grant(input logic [`JSUG_KEY_W-1:0] otp,
                                   input logic [`JSUG_KEY_W-1:0] key);
        grant = (scramble(otp ^ key) == `JSUG_REFERENCE)
              && (otp != '0);
    endfunction : grant

    always_comb begin
        otp_d = otp_q;
        key_d = key_q;
        if (otp_prog_in && otp_addr_in == `JSUG_OTP_ADDR) begin
            otp_d = otp_q & otp_data_in;
        end
        if (key_load_in) begin
            key_d = key_data_in;
        end
        unlock_d = grant(otp_q, key_q);
    end

    // Nonvolatile code: power-on only models a fresh part
    always_ff @(posedge clk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            otp_q <= `JSUG_FACTORY_CODE;
            key_q <= '0;
        end else begin
            otp_q <= otp_d;
            key_q <= key_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            unlock_q <= 1'b0;
        end else begin
            unlock_q <= unlock_d;
        end
    end

    assign unlock_out = unlock_q;

    a_unlock_match: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> unlock_q == $past(grant(otp_q, key_q)))
        else $error("Unlock does not follow the key comparison");

    a_zero_otp_lock: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        otp_q == '0 |=> !unlock_q)
        else $error("Unlocked with an all-zero code");

    a_otp_no_rise: assert property (
        @(posedge clk_in) disable iff (!por_n_in)
        ##1 (otp_q & ~$past(otp_q)) == '0)
        else $error("Code bit went from zero to one");

    a_key_hold: assert property (
        @(posedge clk_in) disable iff (!por_n_in)
        !key_load_in |=> $stable(key_q))
        else $error("Key register changed without a load");

    a_key_load: assert property (
        @(posedge clk_in) disable iff (!por_n_in)
        key_load_in |=> key_q == $past(key_data_in))
        else $error("Key register missed its update");

endmodule : jsug_key_eval

// File: verilog/jsug_guard.sv
// Notes on behaviour
// - Unreadable 128-bit unlock code at OTP address, with no read path
// - XOR stored code with scanned key
// - Mix with secret constants, compare hidden reference
// - Match asserts unlock, otherwise stays secured
// - Factory code and cleared key mean unsecured
// - Stored code bits never return to one until power-on reloads the factory code
// - All-zero code keeps device secured until power-on reloads the factory code
// - Key register cleared only by power-on
// - Secured: only security chain on port 2
// - Secured: other ports, test, boundary blocked
// - Boundary chain sits behind EXTEST and SAMPLE, not a router port
// - Boundary data goes TDI, cells, TDO
`timescale 1ns/100ps
`include "jsug_defs.svh"
module jsug_guard #(
    parameter int NUM_SEC = `JSUG_NUM_SEC,
    parameter int BSR_LEN = `JSUG_BSR_LEN
) (
    input  wire logic                  CLOCK_IN,
    input  wire logic                  ARST_N_IN,
    input  wire logic                  POWER_ON_RESET_N_IN,
    input  wire logic                  TCK_IN,
    input  wire logic                  TMS_IN,
    input  wire logic                  TDI_IN,
    output logic                       TDO_OUT,
    output logic                       TDO_OE_N_OUT,
    input  wire logic                  OTP_PROG_IN,
    input  wire logic [31:0]           OTP_PROG_ADDR_IN,
    input  wire logic [`JSUG_KEY_W-1:0] OTP_PROG_DATA_IN,
    input  wire logic [NUM_SEC-1:0]    CHAIN_TDO_IN,
    input  wire logic                  TEST_TDO_IN,
    input  wire logic [BSR_LEN-1:0]    BSC_PIN_IN,
    output logic [BSR_LEN-1:0]         BSC_PIN_OUT,
    output logic                       BSC_EXTEST_OUT,
    output logic [NUM_SEC-1:0]         CHAIN_SEL_OUT,
    output logic                       TEST_SEL_OUT,
    output logic                       CHAIN_TDI_OUT,
    output logic                       CHAIN_SHIFT_OUT,
    output logic                       CHAIN_CAPTURE_OUT,
    output logic                       CHAIN_UPDATE_OUT,
    output logic                       UNLOCK_OUT
);
    import jsug_pkg::*;

    localparam int PW = (NUM_SEC > 1) ? $clog2(NUM_SEC) : 1;
    localparam logic [PW-1:0] SEC_PORT = PW'(`JSUG_SEC_PORT);

    logic                  rst_n;
    logic [2:0]            sync_a_q;
    logic [2:0]            sync_b_q;
    logic                  tck_prev_q;
    logic                  tck_rise;
    logic                  tck_fall;
    logic                  tms_s;
    logic                  tdi_s;
    logic [BSR_LEN-1:0]    pin_a_q;
    logic [BSR_LEN-1:0]    pin_b_q;
    jsug_tap_t             tap;
    jsug_tgt_t             tgt;
    logic                  unlock;
    logic                  ext_dr;

    logic [`JSUG_IR_W-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
    logic [PW-1:0]         psel_sh_q, psel_sh_d, port_q, port_d;
    logic [`JSUG_KEY_W-1:0] key_sh_q, key_sh_d;
    logic [BSR_LEN-1:0]    bsr_q, bsr_d, bsr_upd_q, bsr_upd_d;
    logic                  bypass_q, bypass_d;
    logic                  key_load_q, key_load_d;

    logic                  tdo_q, tdo_d, oe_n_q, oe_n_d;
    logic [NUM_SEC-1:0]    sel_q, sel_d;
    logic                  test_sel_q, test_sel_d;
    logic                  ctdi_q, ctdi_d;
    logic                  shift_q, shift_d;
    logic                  cap_q, cap_d;
    logic                  upd_q, upd_d;
    logic                  extest_q, extest_d;

    // Power-on also resets the rest of the logic
    assign rst_n = ARST_N_IN & POWER_ON_RESET_N_IN;

    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            sync_a_q   <= 3'h0;
            sync_b_q   <= 3'h0;
            tck_prev_q <= 1'b0;
            pin_a_q    <= '0;
            pin_b_q    <= '0;
        end else begin
            sync_a_q   <= {TDI_IN, TMS_IN, TCK_IN};
            sync_b_q   <= sync_a_q;
            tck_prev_q <= sync_b_q[0];
            pin_a_q    <= BSC_PIN_IN;
            pin_b_q    <= pin_a_q;
        end
    end

    assign tck_rise = sync_b_q[0] & ~tck_prev_q;
    assign tck_fall = ~sync_b_q[0] & tck_prev_q;
    assign tms_s    = sync_b_q[1];
    assign tdi_s    = sync_b_q[2];

    jsug_tap_fsm u_tap (
        .clk_in      (CLOCK_IN),
        .rst_n_in    (rst_n),
        .tck_rise_in (tck_rise),
        .tms_in      (tms_s),
        .state_out   (tap)
    );

    jsug_key_eval u_key (
        .clk_in      (CLOCK_IN),
        .rst_n_in    (rst_n),
        .por_n_in    (POWER_ON_RESET_N_IN),
        .otp_prog_in (OTP_PROG_IN),
        .otp_addr_in (OTP_PROG_ADDR_IN),
        .otp_data_in (OTP_PROG_DATA_IN),
        .key_load_in (key_load_q),
        .key_data_in (key_sh_q),
        .unlock_out  (unlock)
    );

    // Data register reached by the current instruction and lock state
    always_comb begin
        case (ir_q)
            `JSUG_IR_ROUTE:   tgt = TGT_ROUTE;
            `JSUG_IR_SECDR: begin
                if (port_q == SEC_PORT) begin
                    tgt = TGT_KEY;
                end else begin
                    tgt = unlock ? TGT_SEC : TGT_BYPASS;
                end
            end
            `JSUG_IR_TESTTAP: tgt = unlock ? TGT_TEST : TGT_BYPASS;
            `JSUG_IR_SAMPLE,
            `JSUG_IR_EXTEST:  tgt = unlock ? TGT_BSR : TGT_BYPASS;
            default:          tgt = TGT_BYPASS;
        endcase
    end

    assign ext_dr = (tgt == TGT_SEC) || (tgt == TGT_TEST);

    // Instruction and data shift registers
    always_comb begin
        ir_sh_d    = ir_sh_q;
        ir_d       = ir_q;
        psel_sh_d  = psel_sh_q;
        port_d     = port_q;
        key_sh_d   = key_sh_q;
        bsr_d      = bsr_q;
        bsr_upd_d  = bsr_upd_q;
        bypass_d   = bypass_q;
        key_load_d = 1'b0;
        if (tck_rise) begin
            case (tap)
                TAP_RESET: begin
                    ir_d   = `JSUG_IR_BYPASS;
                    port_d = SEC_PORT;
                end
                TAP_CAP_IR:   ir_sh_d = `JSUG_IR_RESET;
                TAP_SHIFT_IR: ir_sh_d = {tdi_s, ir_sh_q[`JSUG_IR_W-1:1]};
                TAP_UPD_IR:   ir_d = ir_sh_q;
                TAP_CAP_DR: begin
                    bypass_d  = 1'b0;
                    psel_sh_d = port_q;
                    key_sh_d  = '0;
                    if (tgt == TGT_BSR) begin
                        bsr_d = pin_b_q;
                    end
                end
                TAP_SHIFT_DR: begin
                    case (tgt)
                        TGT_ROUTE: psel_sh_d = (PW > 1)
                            ? {tdi_s, psel_sh_q[PW-1:1]} : PW'(tdi_s);
                        TGT_KEY: key_sh_d =
                            {tdi_s, key_sh_q[`JSUG_KEY_W-1:1]};
                        TGT_BSR: bsr_d = (BSR_LEN > 1)
                            ? {tdi_s, bsr_q[BSR_LEN-1:1]} : BSR_LEN'(tdi_s);
                        default: bypass_d = tdi_s;
                    endcase
                end
                TAP_UPD_DR: begin
                    case (tgt)
                        TGT_ROUTE: begin
                            if (unlock || psel_sh_q == SEC_PORT) begin
                                port_d = psel_sh_q;
                            end
                        end
                        TGT_KEY: key_load_d = 1'b1;
                        TGT_BSR: bsr_upd_d = bsr_q;
                        default: bypass_d = bypass_q;
                    endcase
                end
                default: ir_d = ir_q;
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_q    <= `JSUG_IR_RESET;
            ir_q       <= `JSUG_IR_BYPASS;
            psel_sh_q  <= '0;
            port_q     <= SEC_PORT;
            key_sh_q   <= '0;
            bsr_q      <= '0;
            bsr_upd_q  <= '0;
            bypass_q   <= 1'b0;
            key_load_q <= 1'b0;
        end else begin
            ir_sh_q    <= ir_sh_d;
            ir_q       <= ir_d;
            psel_sh_q  <= psel_sh_d;
            port_q     <= port_d;
            key_sh_q   <= key_sh_d;
            bsr_q      <= bsr_d;
            bsr_upd_q  <= bsr_upd_d;
            bypass_q   <= bypass_d;
            key_load_q <= key_load_d;
        end
    end

    // Pin-side outputs; TDO changes on the falling TCK edge
    always_comb begin
        tdo_d      = tdo_q;
        oe_n_d     = oe_n_q;
        ctdi_d     = tdi_s;
        sel_d      = '0;
        test_sel_d = (tgt == TGT_TEST);
        extest_d   = (ir_q == `JSUG_IR_EXTEST) && unlock;
        shift_d    = tck_rise && tap == TAP_SHIFT_DR && ext_dr;
        cap_d      = tck_rise && tap == TAP_CAP_DR && ext_dr;
        upd_d      = tck_rise && tap == TAP_UPD_DR && ext_dr;
        if (tgt == TGT_SEC) begin
            sel_d = NUM_SEC'(1) << port_q;
        end
        if (tck_fall) begin
            oe_n_d = !(tap == TAP_SHIFT_IR || tap == TAP_SHIFT_DR);
            if (tap == TAP_SHIFT_IR) begin
                tdo_d = ir_sh_q[0];
            end else begin
                case (tgt)
                    TGT_ROUTE: tdo_d = psel_sh_q[0];
                    TGT_KEY:   tdo_d = key_sh_q[0];
                    TGT_SEC:   tdo_d = CHAIN_TDO_IN[port_q];
                    TGT_TEST:  tdo_d = TEST_TDO_IN;
                    TGT_BSR:   tdo_d = bsr_q[0];
                    default:   tdo_d = bypass_q;
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK_IN or negedge rst_n) begin
        if (!rst_n) begin
            tdo_q      <= 1'b0;
            oe_n_q     <= 1'b1;
            sel_q      <= '0;
            test_sel_q <= 1'b0;
            ctdi_q     <= 1'b0;
            shift_q    <= 1'b0;
            cap_q      <= 1'b0;
            upd_q      <= 1'b0;
            extest_q   <= 1'b0;
        end else begin
            tdo_q      <= tdo_d;
            oe_n_q     <= oe_n_d;
            sel_q      <= sel_d;
            test_sel_q <= test_sel_d;
            ctdi_q     <= ctdi_d;
            shift_q    <= shift_d;
            cap_q      <= cap_d;
            upd_q      <= upd_d;
            extest_q   <= extest_d;
        end
    end

    assign TDO_OUT           = tdo_q;
    assign TDO_OE_N_OUT      = oe_n_q;
    assign CHAIN_SEL_OUT     = sel_q;
    assign TEST_SEL_OUT      = test_sel_q;
    assign CHAIN_TDI_OUT     = ctdi_q;
    assign CHAIN_SHIFT_OUT   = shift_q;
    assign CHAIN_CAPTURE_OUT = cap_q;
    assign CHAIN_UPDATE_OUT  = upd_q;
    assign BSC_PIN_OUT       = bsr_upd_q;
    assign BSC_EXTEST_OUT    = extest_q;
    assign UNLOCK_OUT        = unlock;

    sequence s_locked2;
        !unlock [*2];
    endsequence

    sequence s_key_update;
        tck_rise && tap == TAP_UPD_DR && tgt == TGT_KEY;
    endsequence

    a_locked_blocked: assert property (
        @(posedge CLOCK_IN) disable iff (!rst_n)
        s_locked2 |-> sel_q == '0 && !test_sel_q && !extest_q)
        else $error("Locked device reached a blocked port");

    a_locked_port: assert property (
        @(posedge CLOCK_IN) disable iff (!rst_n)
        !unlock && tck_rise && tap == TAP_UPD_DR && tgt == TGT_ROUTE
        && psel_sh_q != SEC_PORT |=> $stable(port_q))
        else $error("Locked device changed router port");

    a_bsr_shift: assert property (
        @(posedge CLOCK_IN) disable iff (!rst_n)
        tck_rise && tap == TAP_SHIFT_DR && tgt == TGT_BSR
        |=> bsr_q[BSR_LEN-1] == $past(tdi_s))
        else $error("Boundary chain did not take TDI");

    a_key_update: assert property (
        @(posedge CLOCK_IN) disable iff (!rst_n)
        s_key_update |=> key_load_q ##1 !key_load_q)
        else $error("Key load pulse missing at Update-DR");

    a_tdo_drive: assert property (
        @(posedge CLOCK_IN) disable iff (!rst_n)
        tck_fall && tap == TAP_SHIFT_DR |=> !oe_n_q)
        else $error("TDO not driven during Shift-DR");

endmodule : jsug_guard

// File: tb/jsug_host.sv
`timescale 1ns/100ps
`include "jsug_defs.svh"
module jsug_host (
    input  wire logic clk_in,
    input  wire logic tdo_in,
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end

    // One TCK period; TDO read at the end of the high phase
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_out = tms;
        tdi_out = tdi;
        repeat (4) @(posedge clk_in);
        #1 tck_out = 1'b1;
        repeat (4) @(posedge clk_in);
        tdo = tdo_in;
        #1 tck_out = 1'b0;
    endtask : step

    task automatic tlr;
        logic b;
        repeat (5) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask : tlr

    // From Idle through one IR or DR scan back to Idle
    task automatic scan(input logic ir, input int n,
                        input logic [`JSUG_KEY_W-1:0] din,
                        output logic [`JSUG_KEY_W-1:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b0, b);
        if (ir) begin
            step(1'b1, 1'b0, b);
        end
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask : scan
endmodule : jsug_host

// File: tb/jsug_guard_tb.sv
`timescale 1ns/100ps
`include "jsug_defs.svh"
module jsug_guard_tb;
    localparam logic [127:0] FACT = `JSUG_FACTORY_CODE;
    localparam logic [31:0]  ADDR = `JSUG_OTP_ADDR;
    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         por_n = 1'b0;
    logic         tck;
    logic         tms;
    logic         tdi;
    logic         tdo_raw;
    logic         tdo_oe_n;
    logic         otp_prog = 1'b0;
    logic [31:0]  otp_addr = ADDR;
    logic [127:0] otp_data = '1;
    logic [7:0]   pins = 8'h5a;
    logic [7:0]   pins_out;
    logic         extest;
    logic [3:0]   chain_sel;
    logic         test_sel;
    logic         unlock;
    logic         chain_shift;
    int           shifts = 0;
    logic [127:0] rd;
    int           mismatches = 0;
    int           cmp_count = 0;
    int           cycles = 0;
    wire          tdo = tdo_oe_n ? 1'b1 : tdo_raw;

    always #25 clk = ~clk;

    // Count secondary-chain shift pulses where they are settled
    always @(negedge clk) begin
        if (chain_shift === 1'b1) begin
            shifts <= shifts + 1;
        end
    end

    jsug_guard dut (
        .CLOCK_IN            (clk),
        .ARST_N_IN           (arst_n),
        .POWER_ON_RESET_N_IN (por_n),
        .TCK_IN              (tck),
        .TMS_IN              (tms),
        .TDI_IN              (tdi),
        .TDO_OUT             (tdo_raw),
        .TDO_OE_N_OUT        (tdo_oe_n),
        .OTP_PROG_IN         (otp_prog),
        .OTP_PROG_ADDR_IN    (otp_addr),
        .OTP_PROG_DATA_IN    (otp_data),
        .CHAIN_TDO_IN        (4'ha),
        .TEST_TDO_IN         (1'b1),
        .BSC_PIN_IN          (pins),
        .BSC_PIN_OUT         (pins_out),
        .BSC_EXTEST_OUT      (extest),
        .CHAIN_SEL_OUT       (chain_sel),
        .TEST_SEL_OUT        (test_sel),
        .CHAIN_TDI_OUT       (),
        .CHAIN_SHIFT_OUT     (chain_shift),
        .CHAIN_CAPTURE_OUT   (),
        .CHAIN_UPDATE_OUT    (),
        .UNLOCK_OUT          (unlock)
    );

    jsug_host host (
        .clk_in  (clk),
        .tdo_in  (tdo),
        .tck_out (tck),
        .tms_out (tms),
        .tdi_out (tdi)
    );

    task automatic finish_test;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk_flag(input string what, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, g);
        end
    endtask : chk_flag

    task automatic chk_vec(input string what, input logic [127:0] e,
                           input logic [127:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk_vec

    task automatic ir(input logic [3:0] code);
        host.scan(1'b1, 4, {124'h0, code}, rd);
    endtask : ir

    task automatic dr(input int n, input logic [127:0] d);
        host.scan(1'b0, n, d, rd);
    endtask : dr

    task automatic otp_write(input logic [31:0] a, input logic [127:0] d);
        otp_addr = a;
        otp_data = d;
        otp_prog = 1'b1;
        tick(1);
        otp_prog = 1'b0;
        tick(4);
    endtask : otp_write

    task automatic do_reset(input logic por);
        arst_n = 1'b0;
        por_n = ~por;
        tick(8);
        arst_n = 1'b1;
        por_n = 1'b1;
        tick(2);
        host.tlr();
    endtask : do_reset

    task automatic t_boundary;
        ir(`JSUG_IR_EXTEST);
        dr(8, 128'h3c);
        chk_vec("bsr capture", 128'h5a, rd);
        chk_vec("bsr update", 128'h3c, {120'h0, pins_out});
        chk_flag("extest open", 1'b1, extest);
        ir(`JSUG_IR_SAMPLE);
        chk_flag("extest off", 1'b0, extest);
    endtask : t_boundary

    task automatic t_lock;
        otp_write(ADDR + 32'h4, 128'h0);
        chk_flag("unlock bad addr", 1'b1, unlock);
        otp_write(ADDR, ~128'h10);
        chk_flag("unlock locked", 1'b0, unlock);
        otp_write(ADDR, '1);
        chk_flag("unlock after ones", 1'b0, unlock);
    endtask : t_lock

    task automatic t_locked;
        ir(`JSUG_IR_EXTEST);
        chk_flag("extest locked", 1'b0, extest);
        dr(8, 128'hc3);
        chk_vec("bypass locked", 128'h86, rd);
        chk_vec("bsr held", 128'h3c, {120'h0, pins_out});
        ir(`JSUG_IR_TESTTAP);
        chk_flag("test sel locked", 1'b0, test_sel);
        ir(`JSUG_IR_ROUTE);
        dr(2, 128'h1);
        ir(`JSUG_IR_SECDR);
        chk_vec("chain sel locked", 128'h0, {124'h0, chain_sel});
        dr(128, 128'h10);
        tick(2);
        chk_flag("scan_key_register", 1'b1, unlock);
    endtask : t_locked

    task automatic t_open_route;
        ir(`JSUG_IR_TESTTAP);
        chk_flag("test sel open", 1'b1, test_sel);
        ir(`JSUG_IR_ROUTE);
        dr(2, 128'h1);
        ir(`JSUG_IR_SECDR);
        chk_vec("chain sel open", 128'h2, {124'h0, chain_sel});
        shifts = 0;
        dr(4, 128'h0);
        chk_vec("chain tdo open", 128'hf, rd);
        chk_vec("chain shifts", 128'h4, 128'(shifts));
    endtask : t_open_route

    task automatic t_resets;
        do_reset(1'b0);
        chk_flag("unlock warm", 1'b1, unlock);
        do_reset(1'b1);
        chk_flag("unlock power on", 1'b1, unlock);
    endtask : t_resets

    task automatic t_all_zero;
        otp_write(ADDR, 128'h0);
        ir(`JSUG_IR_SECDR);
        dr(128, FACT);
        tick(2);
        chk_flag("unlock all zero", 1'b0, unlock);
    endtask : t_all_zero

    initial begin
        do_reset(1'b1);
        chk_flag("unlock default", 1'b1, unlock);
        t_boundary();
        t_lock();
        t_locked();
        t_open_route();
        t_resets();
        t_all_zero();
        finish_test();
    end
endmodule : jsug_guard_tb
